// ===== src/bfms_seq.v
// Mode sequencer, fault counter, hiccup, prebias and gate drive
`timescale 1ns/1ns
`default_nettype none
`include "bfms_defs.vh"
module bfms_seq #(
  parameter CAL_CYC = `BFMS_CAL_CYC,
  parameter SS_CYC = `BFMS_SS_CYC
) (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Supply and enable comparators, variant and spread-spectrum select
  input wire undervoltage_lockout,
  input wire enable_above_disable,
  input wire [1:0] variant,
  input wire spread_spectrum_mode,
  // Calibration inputs
  input wire trip_clamp_reached,
  input wire [7:0] trip_set_level,
  // Current sense
  input wire [7:0] low_side_drop,
  input wire high_side_trip,
  // Loop inputs
  input wire [7:0] compensation_duty,
  input wire [7:0] feedback_input,
  input wire feedback_in_window,
  // Thermal
  input wire over_temp,
  input wire cooled,
  // Outputs
  output reg high_side_gate_drive,
  output reg low_side_gate_drive,
  output reg internal_bias_regulator,
  output reg output_ok_flag,
  output reg overcurrent_protection,
  output reg [7:0] trip_level,
  output reg [7:0] reg_target,
  output reg [1:0] fault_count,
  output reg hiccup_active
);
  localparam ST_OFF = 3'h0;
  localparam ST_CAL = 3'h1;
  localparam ST_SS = 3'h2;
  localparam ST_RUN = 3'h3;
  localparam ST_HIC = 3'h4;
  localparam ST_HOT = 3'h5;
  localparam [7:0] REF_LVL = 8'h80;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [15:0] timer;
  reg [7:0] ss_level;
  reg [2:0] dummy_left;
  reg start_fault;
  reg oc_seen;
  reg [7:0] valley_hold;
  reg prebias_done;
  reg [7:0] sr_width;
  reg [3:0] dead;
  reg hs_cut;
  reg en_q;
  wire cycle_start;
  wire [7:0] phase;
  wire [7:0] period;
  wire osc_run;
  wire ss_done;
  wire timer_done;
  wire [7:0] on_time;
  wire want_hs;
  wire want_ls;
  wire [7:0] ls_limit;

  function [7:0] min8;
    input [7:0] a;
    input [7:0] b;
    begin
      min8 = (a < b) ? a : b;
    end
  endfunction

  assign osc_run = (state == ST_SS) || (state == ST_RUN) || (state == ST_HIC);
  assign timer_done = (timer == 16'h0000);
  assign ss_done = (state == ST_SS) && timer_done;

  bfms_osc u_osc (
    .clk(clk),
    .rstn(rstn),
    .run(osc_run),
    .variant(variant),
    .spread_spectrum_mode(spread_spectrum_mode),
    .cycle_start(cycle_start),
    .phase(phase),
    .period(period)
  );

  // Mode transitions
  always @* begin
    next_state = state;
    case (state)
      ST_OFF: if (!undervoltage_lockout && enable_above_disable) next_state = ST_CAL;
      ST_CAL: if (timer_done) next_state = ST_SS;
      ST_SS: if (ss_done) next_state = ST_RUN;
      ST_RUN: next_state = ST_RUN;
      ST_HIC: if (timer_done && dummy_left == 3'h0) next_state = ST_SS;
      ST_HOT: if (cooled) next_state = ST_SS;
      default: next_state = ST_OFF;
    endcase
    if ((state == ST_SS || state == ST_RUN) && fault_count == `BFMS_FAULT_LIMIT)
      next_state = ST_HIC;
    if (over_temp && state != ST_OFF && state != ST_CAL && state != ST_HOT)
      next_state = ST_HOT;
    if (undervoltage_lockout || !enable_above_disable) next_state = ST_OFF;
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_OFF;
      timer <= 16'h0000;
      dummy_left <= 3'h0;
      start_fault <= 1'b0;
      en_q <= 1'b0;
    end else begin
      state <= next_state;
      en_q <= enable_above_disable;
      if (next_state != state) begin
        case (next_state)
          ST_CAL: timer <= CAL_CYC[15:0];
          ST_SS: timer <= SS_CYC[15:0];
          ST_HIC: timer <= SS_CYC[15:0];
          default: timer <= 16'h0000;
        endcase
        if (next_state == ST_HIC) begin
          start_fault <= (state == ST_SS);
          dummy_left <= (state == ST_SS) ? `BFMS_DUMMY_START : `BFMS_DUMMY_RUN;
        end
      end else if (!timer_done) begin
        timer <= timer - 16'h0001;
      end else if (state == ST_HIC && dummy_left != 3'h0) begin
        dummy_left <= dummy_left - 3'h1;
        if (dummy_left != 3'h1) timer <= SS_CYC[15:0];
      end
    end
  end

  // Trip level latched once per enable
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      trip_level <= 8'h00;
      overcurrent_protection <= 1'b0;
    end else if (state == ST_OFF) begin
      overcurrent_protection <= 1'b0;
    end else if (state == ST_CAL && timer == 16'h0001) begin
      trip_level <= trip_set_level;
      overcurrent_protection <= !trip_clamp_reached;
    end
  end

  // Soft-start ramp and regulation target
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ss_level <= 8'h00;
      reg_target <= 8'h00;
    end else begin
      if (state != ST_SS && state != ST_RUN) ss_level <= 8'h00;
      else if (state == ST_RUN) ss_level <= 8'hFF;
      else ss_level <= 8'hFF - timer[15:8];
      reg_target <= min8(REF_LVL, ss_level);
    end
  end

  // Fault counter, one step per switching cycle
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      valley_hold <= 8'h00;
      oc_seen <= 1'b0;
      fault_count <= 2'h0;
    end else begin
      if (low_side_gate_drive && phase == period - 8'h02)
        valley_hold <= low_side_drop;
      if (state == ST_HIC && next_state == ST_SS) begin
        fault_count <= 2'h0;
        oc_seen <= 1'b0;
      end else if (cycle_start) begin
        oc_seen <= 1'b0;
        if (oc_seen && fault_count != `BFMS_FAULT_LIMIT)
          fault_count <= fault_count + 2'h1;
        else if (!oc_seen && fault_count != 2'h0)
          fault_count <= fault_count - 2'h1;
      end else if (overcurrent_protection && state != ST_HIC) begin
        if (high_side_trip || (valley_hold > {trip_level[6:0], 1'b0}))
          oc_seen <= 1'b1;
      end
    end
  end

  // Prebias release and synchronous rectifier ramp
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prebias_done <= 1'b0;
      sr_width <= 8'h00;
    end else if (state != ST_SS && state != ST_RUN) begin
      prebias_done <= 1'b0;
      sr_width <= 8'h00;
    end else if (!prebias_done) begin
      prebias_done <= (reg_target > feedback_input);
    end else if (cycle_start && sr_width != 8'hFF) begin
      sr_width <= sr_width + 8'h01;
    end
  end

  assign on_time = min8(compensation_duty, period);
  assign want_hs = prebias_done && (phase < on_time) && !hs_cut
    && !(high_side_trip && overcurrent_protection);
  assign ls_limit = min8(sr_width, period - on_time);
  assign want_ls = prebias_done && (phase >= on_time) && (phase - on_time < ls_limit);

  // Gate drives with dead time
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      high_side_gate_drive <= 1'b0;
      low_side_gate_drive <= 1'b0;
      dead <= 4'h0;
      hs_cut <= 1'b0;
    end else if ((state == ST_SS || state == ST_RUN)
      && (next_state == ST_SS || next_state == ST_RUN)) begin
      if (cycle_start) hs_cut <= 1'b0;
      else if (high_side_trip && high_side_gate_drive && overcurrent_protection)
        hs_cut <= 1'b1;
      if ((high_side_gate_drive && !want_hs) || (low_side_gate_drive && !want_ls)) begin
        high_side_gate_drive <= high_side_gate_drive & want_hs;
        low_side_gate_drive <= low_side_gate_drive & want_ls;
        dead <= `BFMS_DEAD_CYC;
      end else if (dead != 4'h0) begin
        dead <= dead - 4'h1;
      end else if (!high_side_gate_drive && !low_side_gate_drive) begin
        high_side_gate_drive <= want_hs;
        low_side_gate_drive <= want_ls && !want_hs;
      end
    end else begin
      high_side_gate_drive <= 1'b0;
      low_side_gate_drive <= 1'b0;
      dead <= `BFMS_DEAD_CYC;
      hs_cut <= 1'b0;
    end
  end

  // Status outputs
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      internal_bias_regulator <= 1'b0;
      output_ok_flag <= 1'b0;
      hiccup_active <= 1'b0;
    end else begin
      internal_bias_regulator <= (next_state != ST_OFF);
      output_ok_flag <= (state == ST_RUN) && feedback_in_window
        && (fault_count == 2'h0) && !hiccup_active;
      hiccup_active <= (next_state == ST_HIC) || (hiccup_active && next_state != ST_RUN
        && next_state != ST_OFF);
    end
  end
endmodule // bfms_seq
`default_nettype wire

// ===== src/bfms_defs.vh
// Constants for the buck fault and mode sequencer
// Functional notes
// - Add one to fault count when either FET drop exceeds its threshold.
// - Subtract one from fault count in a cycle without overcurrent.
// - Three summed overcurrent events declare a fault and start hiccup.
// - Fault during regulation: four dummy soft-starts then one real attempt.
// - Fault from start-up: five dummy soft-starts then one real attempt.
// - Hiccup retry repeats without limit while the fault persists.
// - High-side overcurrent ends that cycle's high-side on-time.
// - Clamp reached at calibration disables all overcurrent sensing.
// - Low-side overcurrent judged on a sampled and held valley drop.
// - Each enable runs about 2 ms calibration with both drives off.
// - Disable pin level keeps bias regulator off and drives low.
// - Undervoltage lockout keeps bias regulator off and drives low.
// - After calibration enter converting; soft-start then compensation drives gates.
// - Target is lower of reference and offset soft-start level.
// - Prebiased output: no pulses until soft-start exceeds feedback.
// - After prebias release, rectifier on-time grows each cycle to 1-D.
// - Output-ok low on window error, soft-start active, or short circuit.
// - Over-temperature stops PWM and drives; restart with normal soft-start.
// - Spread-spectrum modulates oscillator with triangular 25 kHz profile, 12% span.
// - Oscillator runs at a fixed per-variant frequency while spread-spectrum mode is off.
// - Gate drives never overlap; dead time separates them.
// - Calibrated trip level held until power cycle or enable toggle.
`ifndef BFMS_DEFS_VH
`define BFMS_DEFS_VH
`define BFMS_CLK_HZ 20000000
`define BFMS_CAL_US 2000
`define BFMS_CAL_CYC ((`BFMS_CAL_US * (`BFMS_CLK_HZ / 1000000)))
`define BFMS_SS_CYC 30000
`define BFMS_FAULT_LIMIT 2'h3
`define BFMS_DUMMY_RUN 3'h4
`define BFMS_DUMMY_START 3'h5
`define BFMS_PER_300K 8'h43
`define BFMS_PER_600K 8'h21
`define BFMS_PER_1M2 8'h10
`define BFMS_SPREAD_HZ 25000
`define BFMS_SPREAD_HALF ((`BFMS_CLK_HZ / `BFMS_SPREAD_HZ) / 2)
`define BFMS_SPREAD_DIV 12'h038
`define BFMS_DEAD_CYC 4'h2
`define BFMS_TRIP_W 8
`endif

// ===== src/bfms_osc.v
// Switching-cycle oscillator with triangular spread-spectrum modulation
`timescale 1ns/1ns
`default_nettype none
`include "bfms_defs.vh"
module bfms_osc (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Control
  input wire run,
  input wire [1:0] variant,
  input wire spread_spectrum_mode,
  // Cycle timing
  output reg cycle_start,
  output reg [7:0] phase,
  output reg [7:0] period
);
  reg [15:0] tri_cnt;
  reg tri_up;
  reg [3:0] tri_off;
  reg [7:0] base;
  wire [11:0] spread_prod;
  wire [11:0] spread_add;
  // Seven triangle steps give one eighth of base, above the 12% span
  assign spread_prod = {4'h0, base} * {8'h00, tri_off};
  assign spread_add = spread_prod / `BFMS_SPREAD_DIV;
  always @* begin
    case (variant)
      2'h0: base = `BFMS_PER_300K;
      2'h1: base = `BFMS_PER_600K;
      default: base = `BFMS_PER_1M2;
    endcase
  end
  // Triangle offset, up to about 12% of base above nominal period
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tri_cnt <= 16'h0000;
      tri_up <= 1'b1;
      tri_off <= 4'h0;
    end else if (!spread_spectrum_mode || !run) begin
      tri_cnt <= 16'h0000;
      tri_off <= 4'h0;
      tri_up <= 1'b1;
    end else if (tri_cnt == (`BFMS_SPREAD_HALF / 8) - 1) begin
      tri_cnt <= 16'h0000;
      if (tri_up) begin
        if (tri_off == 4'h7) tri_up <= 1'b0;
        else tri_off <= tri_off + 4'h1;
      end else begin
        if (tri_off == 4'h0) tri_up <= 1'b1;
        else tri_off <= tri_off - 4'h1;
      end
    end else begin
      tri_cnt <= tri_cnt + 16'h0001;
    end
  end
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase <= 8'h00;
      period <= 8'h10;
      cycle_start <= 1'b0;
    end else if (!run) begin
      phase <= 8'h00;
      cycle_start <= 1'b0;
    end else if (phase >= period - 8'h01) begin
      phase <= 8'h00;
      cycle_start <= 1'b1;
      period <= base + spread_add[7:0];
    end else begin
      phase <= phase + 8'h01;
      cycle_start <= 1'b0;
    end
  end
endmodule // bfms_osc
`default_nettype wire

// ===== sim/bfms_seq_asserts.sv
// Concurrent checks for the buck fault and mode sequencer
`timescale 1ns/1ns
`default_nettype none
module bfms_seq_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Inputs
  input wire logic undervoltage_lockout,
  input wire logic enable_above_disable,
  input wire logic high_side_trip,
  input wire logic feedback_in_window,
  input wire logic over_temp,
  // Outputs
  input wire logic high_side_gate_drive,
  input wire logic low_side_gate_drive,
  input wire logic internal_bias_regulator,
  input wire logic output_ok_flag,
  input wire logic overcurrent_protection,
  input wire logic [7:0] reg_target,
  input wire logic [1:0] fault_count,
  input wire logic hiccup_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_hs_off; $fell(high_side_gate_drive); endsequence
  sequence s_ls_quiet; !low_side_gate_drive [*2]; endsequence
  sequence s_all_off; !internal_bias_regulator && !high_side_gate_drive && !low_side_gate_drive;
  endsequence
  a_gates_exclusive: assert property (!(high_side_gate_drive && low_side_gate_drive))
    else $error("Both gate drives high");
  a_dead_time_kept: assert property (s_hs_off |-> s_ls_quiet)
    else $error("Low drive too soon after high drive");
  a_lockout_off: assert property (undervoltage_lockout |=> s_all_off)
    else $error("Active during lockout");
  a_disable_off: assert property (!enable_above_disable |=> s_all_off)
    else $error("Active while disabled");
  a_thermal_off: assert property (over_temp |=> !high_side_gate_drive && !low_side_gate_drive)
    else $error("Drives on at shutdown temperature");
  a_high_limit: assert property (high_side_trip && overcurrent_protection |=> !high_side_gate_drive)
    else $error("High drive kept on past trip");
  a_count_step: assert property ($changed(fault_count) |->
    (fault_count == $past(fault_count) + 2'h1) || (fault_count < $past(fault_count)))
    else $error("Fault count jumped");
  a_fault_hiccup: assert property (fault_count == 2'h3 |-> ##[0:2] hiccup_active)
    else $error("No hiccup after third event");
  a_ok_hiccup: assert property (hiccup_active |=> !output_ok_flag)
    else $error("Output ok during hiccup");
  a_ok_window: assert property (!feedback_in_window |=> !output_ok_flag)
    else $error("Output ok outside window");
  a_target_cap: assert property (reg_target <= 8'h80)
    else $error("Target above reference");
endmodule // bfms_seq_asserts
bind bfms_seq bfms_seq_asserts u_bfms_seq_asserts (.clk, .rstn, .undervoltage_lockout,
  .enable_above_disable, .high_side_trip, .feedback_in_window, .over_temp,
  .high_side_gate_drive, .low_side_gate_drive, .internal_bias_regulator, .output_ok_flag,
  .overcurrent_protection, .reg_target, .fault_count, .hiccup_active);
`default_nettype wire

// ===== sim/bfms_fet_model.sv
// Behavioural model of the external power FET pair and its drop sensing
`timescale 1ns/1ns
`default_nettype none
module bfms_fet_model (
  // Clock
  input wire logic clk,
  // Gate drives
  input wire logic high_side_gate_drive,
  input wire logic low_side_gate_drive,
  // Load control
  input wire logic short_load,
  // Sensed drops
  output var logic [7:0] low_side_drop,
  output var logic high_side_trip
);
  initial low_side_drop = 8'h00;
  // Drop is only meaningful while the low FET conducts
  always @(posedge clk) begin
    if (low_side_gate_drive) begin
      low_side_drop <= short_load ? 8'hF0 : 8'h04;
    end else begin
      low_side_drop <= ~low_side_drop;
    end
  end
  assign high_side_trip = high_side_gate_drive && short_load;
endmodule // bfms_fet_model
`default_nettype wire

// ===== sim/bfms_seq_tb.sv
// Self-checking testbench for the buck fault and mode sequencer
`timescale 1ns/1ns
`default_nettype none
module bfms_seq_tb;
  logic clk, rstn, undervoltage_lockout, enable_above_disable, spread_spectrum_mode;
  logic trip_clamp_reached, feedback_in_window, over_temp, cooled, short_load, high_side_trip;
  logic [1:0] variant;
  logic [7:0] trip_set_level, low_side_drop, compensation_duty, feedback_input;
  wire high_side_gate_drive, low_side_gate_drive, internal_bias_regulator, output_ok_flag;
  wire overcurrent_protection, hiccup_active;
  wire [7:0] reg_target;
  wire [1:0] fault_count;
  int num_errors = 0;
  int checks = 0;
  bfms_seq #(.CAL_CYC(50), .SS_CYC(64)) u_bfms_seq (.clk, .rstn, .undervoltage_lockout,
    .enable_above_disable, .variant, .spread_spectrum_mode, .trip_clamp_reached,
    .trip_set_level, .low_side_drop, .high_side_trip, .compensation_duty, .feedback_input,
    .feedback_in_window, .over_temp, .cooled, .high_side_gate_drive, .low_side_gate_drive,
    .internal_bias_regulator, .output_ok_flag, .overcurrent_protection, .trip_level(),
    .reg_target, .fault_count, .hiccup_active);
  bfms_fet_model u_bfms_fet_model (.clk, .high_side_gate_drive, .low_side_gate_drive,
    .short_load, .low_side_drop, .high_side_trip);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task end_of_test;
    $display("Counts: %0d checks, %0d mismatches", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  function automatic logic cond(input int which);
    case (which)
      0: return high_side_gate_drive === 1'b1;
      1: return hiccup_active === 1'b1;
      2: return hiccup_active === 1'b0;
      default: return output_ok_flag === 1'b1;
    endcase
  endfunction
  task automatic wait_for(input int which, input int bound);
    for (int n = 0; n < bound; n++) begin
      if (cond(which)) return;
      step(1);
    end
    chk(1'b0, "wait bound used up");
    end_of_test();
  endtask
  task test_off;
    step(3);
    chk({internal_bias_regulator, high_side_gate_drive, low_side_gate_drive} === 3'h0, "lockout");
    undervoltage_lockout = 1'b0;
    step(3);
    chk({internal_bias_regulator, high_side_gate_drive, low_side_gate_drive} === 3'h0, "disable");
    $display("test_off done");
  endtask
  task test_start;
    enable_above_disable = 1'b1;
    step(2);
    chk(internal_bias_regulator === 1'b1, "bias regulator off");
    repeat (40) begin
      step(1);
      chk({high_side_gate_drive, low_side_gate_drive} === 2'h0, "drive in calibration");
    end
    wait_for(0, 400);
    wait_for(3, 400);
    chk(reg_target === 8'h80, "target not at reference");
    chk(overcurrent_protection === 1'b1, "protection off");
    feedback_in_window = 1'b0;
    step(2);
    chk(output_ok_flag === 1'b0, "ok outside window");
    feedback_in_window = 1'b1;
    wait_for(3, 10);
    $display("test_start done");
  endtask
  task test_fault;
    short_load = 1'b1;
    wait_for(1, 400);
    chk(output_ok_flag === 1'b0, "ok during fault");
    step(236);
    chk(hiccup_active === 1'b1, "hiccup too short");
    wait_for(0, 200);
    wait_for(1, 400);
    short_load = 1'b0;
    wait_for(2, 600);
    chk(fault_count === 2'h0, "count not cleared");
    wait_for(0, 300);
    $display("test_fault done");
  endtask
  task test_thermal;
    over_temp = 1'b1;
    step(2);
    chk({high_side_gate_drive, low_side_gate_drive} === 2'h0, "drives at shutdown");
    over_temp = 1'b0;
    cooled = 1'b1;
    wait_for(0, 400);
    cooled = 1'b0;
    $display("test_thermal done");
  endtask
  task test_clamp;
    enable_above_disable = 1'b0;
    step(3);
    trip_clamp_reached = 1'b1;
    enable_above_disable = 1'b1;
    wait_for(0, 400);
    chk(overcurrent_protection === 1'b0, "protection kept");
    short_load = 1'b1;
    step(300);
    chk(hiccup_active === 1'b0, "sensing while disabled");
    $display("test_clamp done");
  endtask
  initial begin
    {rstn, enable_above_disable, spread_spectrum_mode, trip_clamp_reached} = 4'h0;
    {over_temp, cooled, short_load} = 3'h0;
    undervoltage_lockout = 1'b1;
    feedback_in_window = 1'b1;
    variant = 2'h1;
    trip_set_level = 8'h10;
    compensation_duty = 8'h0C;
    feedback_input = 8'h00;
    step(12);
    rstn = 1'b1;
    spread_spectrum_mode = 1'b1;
    test_off();
    test_start();
    test_fault();
    test_thermal();
    test_clamp();
    end_of_test();
  end
endmodule // bfms_seq_tb
`default_nettype wire
